/* src/plm_mode_ctrl.sv */
// primary mode control register, pointer and pwm clock sequencing
`timescale 1ns/100ps
`default_nettype none
// How it works
// - bit 7 shows resume; write one clears while awake
// - pin activity harmless while asleep
// - clock select sticky until software reset
// - clock select chooses oscillator or pin
// - refresh rate is clock over 4096(prescale+1)
// - auto increment advances pointer after access
// - bit 4 sleep, stops oscillator, resets set
// - oscillator running within 500 us
// - external clock needs no start delay
// - no pwm activity while oscillator stopped in sleep
// - bit 0 enables group address, resets one
// - prescale writes ignored while awake
// - sleep with active channels sets resume
// - writing resume one while set and awake restarts channels
// - pointer wraps 69 to 0, 254 to 0
module plm_mode_ctrl
#(
    parameter int OSC_START_CYCLES = plm_pkg::OSC_START_CYC,
    parameter int OSC_DIV          = plm_pkg::OSC_DIV_DEFAULT
)
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        soft_reset,
    // register port from the bus slave
    input  wire logic        ptr_load,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_ptr,
    output logic [7:0]       reg_rdata,
    output logic             reg_hit,
    // pins and pwm channel status
    input  wire logic        ext_clk_pin,
    input  wire logic        channels_active,
    // address match enables
    output logic             secondary_addr_one_enable,
    output logic             secondary_addr_two_enable,
    output logic             secondary_addr_three_enable,
    output logic             group_address_enable,
    // pwm timebase
    output logic             pwm_run,
    output logic [11:0]      pwm_count,
    output logic             pwm_cycle_end,
    output logic             pwm_restart,
    output logic             pwm_freeze
);
    logic [7:0]         mode_ff;
    logic [7:0]         prescale_ff;
    logic [7:0]         ptr_ff;
    logic               resume_ff;
    logic               ext_sel_ff;
    logic               restart_ff;
    logic [16:0]        start_cnt_ff;
    plm_pkg::plm_state_t state_ff;
    plm_pkg::plm_state_t nxt_state;
    logic               mode_wr;
    logic               pre_wr;
    logic               sleep;
    logic               resume_set;
    logic               resume_clr;
    logic               osc_on;
    logic               pwm_enable;
    logic               cycle_end;

    plm_tick_if tick_bus ();

    assign mode_wr = reg_wr && ptr_ff == plm_pkg::PRIMARY_MODE_OFS;
    assign pre_wr  = reg_wr && ptr_ff == plm_pkg::PRESCALE_OFS;
    assign sleep   = mode_ff[plm_pkg::SLEEP_BIT];

    // ------------------------------------------------------------
    // plain mode bits
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_ff <= plm_pkg::PRIMARY_MODE_RST;
        else if (soft_reset)
            mode_ff <= plm_pkg::PRIMARY_MODE_RST;
        else if (mode_wr)
            mode_ff <= reg_wdata;
    end

    // ------------------------------------------------------------
    // sticky clock select
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ext_sel_ff <= 1'b0;
        else if (soft_reset)
            ext_sel_ff <= 1'b0;
        else if (mode_wr && reg_wdata[plm_pkg::EXT_CLK_BIT])
            ext_sel_ff <= 1'b1;
    end

    // ------------------------------------------------------------
    // prescale, writable only in sleep
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            prescale_ff <= plm_pkg::PRESCALE_RST;
        else if (soft_reset)
            prescale_ff <= plm_pkg::PRESCALE_RST;
        else if (pre_wr && sleep)
            prescale_ff <= reg_wdata;
    end

    // ------------------------------------------------------------
    // register pointer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ptr_ff <= plm_pkg::POINTER_RST;
        else if (soft_reset)
            ptr_ff <= plm_pkg::POINTER_RST;
        else if (ptr_load)
            ptr_ff <= reg_wdata;
        else if ((reg_wr || reg_rd) && mode_ff[plm_pkg::AUTO_INC_BIT])
        begin
            if (ptr_ff == plm_pkg::LAST_CHANNEL_OFS || ptr_ff >= plm_pkg::LAST_BCAST_OFS)
                ptr_ff <= plm_pkg::PRIMARY_MODE_OFS;
            else if (ptr_ff > plm_pkg::LAST_CHANNEL_OFS && ptr_ff < plm_pkg::FIRST_BCAST_OFS)
                ptr_ff <= plm_pkg::PRIMARY_MODE_OFS;
            else
                ptr_ff <= ptr_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // wake sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            plm_pkg::PLM_ASLEEP:
                if (!sleep)
                    nxt_state = ext_sel_ff ? plm_pkg::PLM_RUNNING
                                           : plm_pkg::PLM_STARTING;
            plm_pkg::PLM_STARTING:
                if (sleep)
                    nxt_state = plm_pkg::PLM_ASLEEP;
                else if (start_cnt_ff == 17'(OSC_START_CYCLES - 1))
                    nxt_state = plm_pkg::PLM_RUNNING;
            plm_pkg::PLM_RUNNING:
                if (sleep)
                    nxt_state = channels_active ? plm_pkg::PLM_DRAINING
                                                : plm_pkg::PLM_ASLEEP;
            plm_pkg::PLM_DRAINING:
                if (!sleep)
                    nxt_state = plm_pkg::PLM_RUNNING;
                else if (cycle_end)
                    nxt_state = plm_pkg::PLM_ASLEEP;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= plm_pkg::PLM_ASLEEP;
        else if (soft_reset)
            state_ff <= plm_pkg::PLM_ASLEEP;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            start_cnt_ff <= 17'h00000;
        else if (state_ff != plm_pkg::PLM_STARTING || soft_reset)
            start_cnt_ff <= 17'h00000;
        else
            start_cnt_ff <= start_cnt_ff + 17'h00001;
    end

    // oscillator stops in sleep; with channels active a refresh in progress is allowed to finish
    assign osc_on     = !ext_sel_ff && state_ff != plm_pkg::PLM_ASLEEP;
    assign pwm_enable = state_ff == plm_pkg::PLM_RUNNING
                     || state_ff == plm_pkg::PLM_DRAINING;

    // ------------------------------------------------------------
    // resume flag
    // ------------------------------------------------------------
    assign resume_set = state_ff == plm_pkg::PLM_DRAINING && sleep && cycle_end;
    assign resume_clr = mode_wr && reg_wdata[plm_pkg::RESUME_BIT] && !sleep;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            resume_ff <= 1'b0;
        else if (soft_reset)
            resume_ff <= 1'b0;
        else if (resume_set)
            resume_ff <= 1'b1;
        else if (resume_clr)
            resume_ff <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            restart_ff <= 1'b0;
        else
            restart_ff <= resume_clr && resume_ff && !resume_set;
    end

    // ------------------------------------------------------------
    // clock source and timebase
    // ------------------------------------------------------------
    plm_clk_src
    #(
        .OSC_DIV     (OSC_DIV)
    )
    u_clk_src
    (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .ext_sel     (ext_sel_ff),
        .osc_on      (osc_on),
        .pwm_enable  (pwm_enable),
        .ext_clk_pin (ext_clk_pin),
        .tck         (tick_bus.src)
    );

    plm_timebase
    #(
        .CNT_W       (12)
    )
    u_timebase
    (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .prescale    (prescale_ff),
        .clear       (soft_reset),
        .tck         (tick_bus.sink),
        .count       (pwm_count),
        .cycle_end   (cycle_end)
    );

    // ------------------------------------------------------------
    // read data and outputs
    // ------------------------------------------------------------
    always_comb
    begin
        reg_rdata = 8'h00;
        reg_hit   = 1'b0;
        if (ptr_ff == plm_pkg::PRIMARY_MODE_OFS)
        begin
            reg_rdata = {resume_ff, ext_sel_ff, mode_ff[5:0]};
            reg_hit   = 1'b1;
        end
        else if (ptr_ff == plm_pkg::PRESCALE_OFS)
        begin
            reg_rdata = prescale_ff;
            reg_hit   = 1'b1;
        end
    end

    assign reg_ptr                     = ptr_ff;
    assign secondary_addr_one_enable   = mode_ff[plm_pkg::SEC_ONE_BIT];
    assign secondary_addr_two_enable   = mode_ff[plm_pkg::SEC_TWO_BIT];
    assign secondary_addr_three_enable = mode_ff[plm_pkg::SEC_THREE_BIT];
    assign group_address_enable        = mode_ff[plm_pkg::GROUP_BIT];
    assign pwm_run                     = tick_bus.run;
    assign pwm_cycle_end               = cycle_end;
    assign pwm_restart                 = restart_ff;
    assign pwm_freeze                  = !pwm_enable;
endmodule
`default_nettype wire

/* src/plm_pkg.sv */
// constants for the primary mode control block
package plm_pkg;

    // ------------------------------------------------------------
    // register offsets and pointer wrap points
    // ------------------------------------------------------------
    localparam logic [7:0] PRIMARY_MODE_OFS  = 8'h00;
    localparam logic [7:0] PRESCALE_OFS      = 8'hfe;
    localparam logic [7:0] LAST_CHANNEL_OFS  = 8'h45;
    localparam logic [7:0] FIRST_BCAST_OFS   = 8'hfa;
    localparam logic [7:0] LAST_BCAST_OFS    = 8'hfe;

    // ------------------------------------------------------------
    // primary mode field positions
    // ------------------------------------------------------------
    localparam int RESUME_BIT      = 7;
    localparam int EXT_CLK_BIT     = 6;
    localparam int AUTO_INC_BIT    = 5;
    localparam int SLEEP_BIT       = 4;
    localparam int SEC_ONE_BIT     = 3;
    localparam int SEC_TWO_BIT     = 2;
    localparam int SEC_THREE_BIT   = 1;
    localparam int GROUP_BIT       = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PRIMARY_MODE_RST  = 8'h11;
    localparam logic [7:0] PRESCALE_RST      = 8'h03;
    localparam logic [7:0] POINTER_RST       = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_MHZ    = 100;
    localparam int OSC_START_US    = 500;
    localparam int OSC_START_CYC   = OSC_START_US * CORE_CLK_MHZ;
    localparam int PWM_STEPS       = 4096;
    localparam int OSC_DIV_DEFAULT = 4;

    // ------------------------------------------------------------
    // wake sequencing states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PLM_ASLEEP   = 2'b00,
        PLM_STARTING = 2'b01,
        PLM_RUNNING  = 2'b10,
        PLM_DRAINING = 2'b11
    } plm_state_t;

endpackage

/* src/plm_tick_if.sv */
// tick carrier between clock source and pwm timebase
`timescale 1ns/100ps
`default_nettype none
interface plm_tick_if;
    logic tick;
    logic run;

    modport src
    (
        output tick,
        output run
    );

    modport sink
    (
        input  tick,
        input  run
    );
endinterface
`default_nettype wire

/* src/plm_clk_src.sv */
// pwm clock source: divided internal oscillator or synced external pin
`timescale 1ns/100ps
`default_nettype none
module plm_clk_src
#(
    parameter int OSC_DIV = plm_pkg::OSC_DIV_DEFAULT
)
(
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    // control
    input  wire logic   ext_sel,
    input  wire logic   osc_on,
    input  wire logic   pwm_enable,
    input  wire logic   ext_clk_pin,
    // tick out
    plm_tick_if.src     tck
);
    logic [1:0]  ext_sync_ff;
    logic        ext_prev_ff;
    logic [15:0] osc_div_ff;
    logic        osc_tick;
    logic        ext_tick;

    // ------------------------------------------------------------
    // external pin synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_sync_ff <= 2'h0;
            ext_prev_ff <= 1'b0;
        end
        else
        begin
            ext_sync_ff <= {ext_sync_ff[0], ext_clk_pin};
            ext_prev_ff <= ext_sync_ff[1];
        end
    end

    assign ext_tick = ext_sync_ff[1] & ~ext_prev_ff;

    // ------------------------------------------------------------
    // internal oscillator model, stopped in sleep
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            osc_div_ff <= 16'h0000;
        else if (!osc_on || osc_div_ff == 16'(OSC_DIV - 1))
            osc_div_ff <= 16'h0000;
        else
            osc_div_ff <= osc_div_ff + 16'h0001;
    end

    assign osc_tick = osc_on && osc_div_ff == 16'(OSC_DIV - 1);

    // pin edges pass only while awake, so a live pin during the switch is harmless
    assign tck.tick = pwm_enable & (ext_sel ? ext_tick : osc_tick);
    assign tck.run  = pwm_enable;
endmodule
`default_nettype wire

/* src/plm_timebase.sv */
// pwm prescaler and 12-bit refresh counter
`timescale 1ns/100ps
`default_nettype none
module plm_timebase
#(
    parameter int CNT_W = 12
)
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // control
    input  wire logic [7:0]        prescale,
    input  wire logic              clear,
    // tick in
    plm_tick_if.sink               tck,
    // status
    output logic [CNT_W-1:0]       count,
    output logic                   cycle_end
);
    logic [7:0]       pre_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             step;

    // ------------------------------------------------------------
    // prescale divides source ticks by prescale plus one
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pre_ff <= 8'h00;
        else if (clear)
            pre_ff <= 8'h00;
        else if (tck.tick)
            pre_ff <= (pre_ff >= prescale) ? 8'h00 : pre_ff + 8'h01;
    end

    assign step = tck.tick && pre_ff >= prescale;

    // ------------------------------------------------------------
    // refresh counter, one refresh per full wrap
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= '0;
        else if (clear)
            cnt_ff <= '0;
        else if (step)
            cnt_ff <= cnt_ff + 1'b1;
    end

    assign count     = cnt_ff;
    assign cycle_end = step && (&cnt_ff);
endmodule
`default_nettype wire

/* test/plm_mode_ctrl_sva.sv */
// assertions on the primary mode control ports
`timescale 1ns/100ps
`default_nettype none
module plm_mode_ctrl_sva
#(
    parameter int OSC_START_CYCLES = 20
)
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       soft_reset,
    // register port
    input wire logic       ptr_load,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_ptr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_hit,
    // enables and pwm
    input wire logic       secondary_addr_one_enable,
    input wire logic       secondary_addr_two_enable,
    input wire logic       secondary_addr_three_enable,
    input wire logic       group_address_enable,
    input wire logic       pwm_run,
    input wire logic       pwm_restart,
    input wire logic       pwm_freeze
);
    localparam int WAKE_LO = OSC_START_CYCLES - 2;
    localparam int WAKE_HI = OSC_START_CYCLES + 3;
    logic mode_wr;
    logic ai_ff;
    assign mode_wr = reg_wr && !ptr_load && !soft_reset && reg_ptr == 8'h00;
    // auto increment shadow
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ai_ff <= 1'b0;
        else if (soft_reset)
            ai_ff <= 1'b0;
        else if (mode_wr)
            ai_ff <= reg_wdata[5];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence step_s;
        (reg_wr || reg_rd) && !ptr_load && !soft_reset && ai_ff;
    endsequence
    sequence wake_s;
        mode_wr && !ai_ff && reg_rdata[4] && !reg_wdata[4] && !pwm_run;
    endsequence
    chk_ptr_step: assert property (
        step_s ##0 reg_ptr inside {[8'h01:8'h44], [8'hfa:8'hfd]}
        |=> reg_ptr == $past(reg_ptr) + 8'h01) else $error("pointer did not advance");
    chk_ptr_wrap: assert property (
        step_s ##0 reg_ptr inside {[8'h45:8'hf9], [8'hfe:8'hff]}
        |=> reg_ptr == 8'h00) else $error("pointer did not wrap");
    chk_enable_mirror: assert property (
        reg_ptr == 8'h00 |-> group_address_enable == reg_rdata[0] && {secondary_addr_one_enable,
        secondary_addr_two_enable, secondary_addr_three_enable} == reg_rdata[3:1])
        else $error("address enables differ from mode bits");
    chk_read_decode: assert property (
        reg_hit == (reg_ptr == 8'h00 || reg_ptr == 8'hfe) && (reg_hit || reg_rdata == 8'h00))
        else $error("read decode wrong");
    chk_freeze_run: assert property (pwm_freeze != pwm_run)
        else $error("freeze not inverse of run");
    chk_asleep_still: assert property (
        reg_ptr == 8'h00 && reg_rdata[4] && !pwm_run && !mode_wr |=> !pwm_run)
        else $error("pwm ran while asleep");
    chk_ext_sticky: assert property (
        mode_wr && !ai_ff && reg_rdata[6] |=> reg_rdata[6]) else $error("clock select cleared");
    chk_resume_clear: assert property (
        mode_wr && !ai_ff && reg_rdata[7] && !reg_rdata[4] && reg_wdata[7]
        |=> !reg_rdata[7] && pwm_restart) else $error("resume not cleared with restart");
    chk_resume_keep: assert property (
        mode_wr && !ai_ff && reg_rdata[7] && !reg_wdata[7] |=> reg_rdata[7])
        else $error("resume lost on zero write");
    chk_restart_pulse: assert property (pwm_restart |=> !pwm_restart)
        else $error("restart longer than one cycle");
    chk_wake_ext: assert property (wake_s ##0 reg_rdata[6] |=> ##[0:1] pwm_run)
        else $error("external wake delayed");
    chk_wake_hold: assert property (wake_s ##0 !reg_rdata[6] |=> (!pwm_run)[*8])
        else $error("ran before oscillator start");
    chk_wake_int: assert property (
        wake_s ##0 !reg_rdata[6] |-> ##[WAKE_LO:WAKE_HI] pwm_run)
        else $error("oscillator start late");
endmodule
`default_nettype wire

/* test/plm_host.sv */
// host model driving the register port
`timescale 1ns/100ps
`default_nettype none
module plm_host
#(
    parameter int START_WAIT = 20
)
(
    // clock
    input  wire logic       core_clk,
    // register port
    output logic            ptr_load,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        ptr_load = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic op(input logic [2:0] k, input logic [7:0] d);
        @(posedge core_clk);
        ptr_load <= k[2];
        reg_wr <= k[1];
        reg_rd <= k[0];
        reg_wdata <= d;
    endtask
    task automatic set_ptr(input logic [7:0] a);
        op(3'b100, a);
    endtask
    task automatic wr(input logic [7:0] d);
        op(3'b010, d);
    endtask
    task automatic idle();
        op(3'b000, ~reg_wdata);
    endtask
    task automatic rd(output logic [7:0] d);
        op(3'b001, ~reg_wdata);
        @(posedge core_clk);
        d = reg_rdata;
        reg_rd <= 1'b0;
        reg_wdata <= ~reg_wdata;
    endtask
    // sleep first, then sleep with clock select
    task automatic ext_switch(input logic [7:0] m);
        set_ptr(8'h00);
        wr(m | 8'h10);
        wr(m | 8'h50);
        idle();
    endtask
    // no pwm access inside the start window
    task automatic settle();
        repeat (START_WAIT + 4) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the primary mode control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       core_clk;
    logic       rst_n;
    logic       soft_reset;
    logic       ext_clk_pin;
    logic       channels_active;
    logic       ptr_load;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_ptr;
    logic [7:0] reg_rdata;
    logic       reg_hit;
    logic [11:0] pwm_count;
    logic [11:0] cnt_hold;
    logic [2:0] subs;
    logic       group_address_enable;
    logic       pwm_run;
    logic       pwm_cycle_end;
    logic       pwm_restart;
    logic       pwm_freeze;
    logic [7:0] mode_m;
    logic [7:0] rnd;
    logic [7:0] d;
    int         error_cnt;
    int         checks;
    int         restart_cnt;
    int         n;
    localparam int START_CYC = 20;
    plm_mode_ctrl #(.OSC_START_CYCLES(START_CYC)) u_plm_mode_ctrl (.core_clk, .rst_n,
        .soft_reset, .ptr_load, .reg_wr, .reg_rd, .reg_wdata, .reg_ptr, .reg_rdata,
        .reg_hit, .ext_clk_pin, .channels_active, .secondary_addr_one_enable(subs[2]),
        .secondary_addr_two_enable(subs[1]), .secondary_addr_three_enable(subs[0]),
        .group_address_enable, .pwm_run, .pwm_count, .pwm_cycle_end, .pwm_restart,
        .pwm_freeze);
    plm_host #(.START_WAIT(START_CYC)) u_plm_host (.core_clk, .ptr_load, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] nxt_mode(input logic [7:0] m, input logic [7:0] w);
        nxt_mode = w;
        nxt_mode[7] = m[7] & ~(w[7] & ~m[4]);
        nxt_mode[6] = m[6] | (w[6] & w[4] & m[4]);
    endfunction
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic wmode(input logic [7:0] v);
        u_plm_host.set_ptr(8'h00);
        u_plm_host.wr(v);
        u_plm_host.idle();
        mode_m = nxt_mode(mode_m, v);
    endtask
    task automatic rmode();
        u_plm_host.set_ptr(8'h00);
        u_plm_host.rd(d);
        cmp("mode", mode_m, d);
    endtask
    task automatic wpre(input logic [7:0] v);
        u_plm_host.set_ptr(8'hfe);
        u_plm_host.wr(v);
        u_plm_host.idle();
        u_plm_host.set_ptr(8'hfe);
        u_plm_host.rd(d);
    endtask
    task automatic wait_end();
        n = 0;
        while (pwm_cycle_end !== 1'b1 && n < 20000)
        begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
        if (pwm_restart === 1'b1)
            restart_cnt++;
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        ext_clk_pin = 1'b0;
        #3;
        forever #20 ext_clk_pin = ~ext_clk_pin;
    end
    initial
    begin
        repeat (90000) @(posedge core_clk);
        error_cnt++;
        results();
    end
    initial
    begin
        rst_n = 1'b0;
        soft_reset = 1'b0;
        channels_active = 1'b0;
        error_cnt = 0;
        checks = 0;
        restart_cnt = 0;
        rnd = 8'h0a;
        mode_m = 8'h11;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rmode();
        cmp("freeze", 1, pwm_freeze);
        repeat (12)
        begin
            rnd = lfsr(rnd);
            channels_active <= rnd[7];
            wmode((rnd & 8'h8f) | 8'h10);
            rmode();
            cmp("subs", mode_m[3:1], subs);
            cmp("group", mode_m[0], group_address_enable);
            cmp("run", 0, pwm_run);
        end
        channels_active <= 1'b0;
        wpre(8'h07);
        cmp("prescale", 8'h07, d);
        wmode(8'h01);
        u_plm_host.settle();
        cmp("run", 1, pwm_run);
        wpre(8'h22);
        cmp("prescale", 8'h07, d);
        wmode(8'h11);
        repeat (4) @(posedge core_clk);
        cmp("run", 0, pwm_run);
        wpre(8'h00);
        u_plm_host.ext_switch(8'h01);
        mode_m = nxt_mode(nxt_mode(mode_m, 8'h11), 8'h51);
        wmode(8'h11);
        rmode();
        cnt_hold = pwm_count;
        repeat (40) @(posedge core_clk);
        cmp("run", 0, pwm_run);
        cmp("count", cnt_hold, pwm_count);
        channels_active <= 1'b1;
        wmode(8'h41);
        repeat (3) @(posedge core_clk);
        cmp("run", 1, pwm_run);
        wait_end();
        @(posedge core_clk);
        wait_end();
        cmp("count", 16'h0fff, pwm_count);
        cmp("period", 4096 * (0 + 1) * 4, n + 1);
        wmode(8'h51);
        repeat (3) @(posedge core_clk);
        cmp("run", 1, pwm_run);
        wait_end();
        repeat (3) @(posedge core_clk);
        cmp("run", 0, pwm_run);
        mode_m[7] = 1'b1;
        rmode();
        wmode(8'h41);
        rmode();
        wmode(8'hc1);
        rmode();
        cmp("restarts", 1, restart_cnt);
        @(posedge core_clk);
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        mode_m = 8'h11;
        rmode();
        wmode(8'h31);
        u_plm_host.set_ptr(8'h44);
        u_plm_host.rd(d);
        u_plm_host.rd(d);
        @(posedge core_clk);
        cmp("ptr", 8'h00, reg_ptr);
        u_plm_host.set_ptr(8'hfa);
        repeat (4)
        begin
            u_plm_host.rd(d);
            cmp("unmapped", 8'h00, d);
            cmp("hit", 0, reg_hit);
        end
        u_plm_host.rd(d);
        cmp("prescale", plm_pkg::PRESCALE_RST, d);
        cmp("hit", 1, reg_hit);
        @(posedge core_clk);
        cmp("ptr", 8'h00, reg_ptr);
        results();
    end
endmodule
bind plm_mode_ctrl plm_mode_ctrl_sva #(.OSC_START_CYCLES(OSC_START_CYCLES)) u_sva (.core_clk,
    .rst_n, .soft_reset, .ptr_load, .reg_wr, .reg_rd, .reg_wdata, .reg_ptr, .reg_rdata,
    .reg_hit, .secondary_addr_one_enable, .secondary_addr_two_enable,
    .secondary_addr_three_enable, .group_address_enable, .pwm_run, .pwm_restart, .pwm_freeze);
`default_nettype wire
